// ==== src/frs_map.svh ====
/*
 Offsets, opcode fields, reset values and timing counts for the file-register
 execution block. Assumes a 14-bit instruction word and a 7-bit file address.
*/
// Operation
// - Op 000111 adds accumulator and file, sets carry, nibble carry and zero, in one cycle.
// - Add with destination zero puts the sum in the accumulator and leaves the file alone.
// - Add with destination one writes the sum to the file and leaves the accumulator alone.
// - Op 000101 ANDs accumulator and file, updates only zero, in one cycle.
// - AND sends its result to the accumulator for destination zero, to the file for one.
// - Top bits 0110 test a bit; a zero bit discards the next word for one idle cycle.
// - A read-modify-write of a port register takes its source from the pin levels.
// - A write to timer zero count with the prescaler on the timer clears the prescaler.
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH
`define FRS_OP_ADD 6'h07
`define FRS_OP_AND 6'h05
`define FRS_OP_BCLR 4'h4
`define FRS_OP_BTSZ 4'h6
`define FRS_DEST_BIT 7
`define FRS_BSEL_HI 9
`define FRS_BSEL_LO 7
`define FRS_TMR_ADDR 7'h01
`define FRS_ACC_RST 8'h00
`define FRS_SKIP_CYCLES 2
`endif

// ==== src/frs_pkg.sv ====
/*
 Types for the file-register execution block.
 Assumes the constants of frs_map.svh are included where numbers are needed.
*/
`default_nettype none
package frs_pkg;
   // One write towards the register file
   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } frs_wr_t;

   // Status flags owned by the block
   typedef struct packed {
      logic carry;
      logic nibble_overflow_flag;
      logic zero;
   } frs_flags_t;

   // Execution phase
   typedef enum logic [0:0] {
      FRS_RUN = 1'b0,
      FRS_IDLE = 1'b1
   } frs_state_t;
endpackage
`default_nettype wire

// ==== src/frs_exec.sv ====
/*
 Execution of add, AND, bit clear and bit test-skip on file registers.
 Assumes the register file answers file_raddr combinationally on file_rdata,
 writes file_wr at the edge after it is shown, and that the fetch path drops
 the word presented while idle_cycle is high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "frs_map.svh"
module frs_exec (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Instruction in
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   // Register file read side
   output logic [6:0] file_raddr,
   input wire logic [7:0] file_rdata,
   input wire logic file_is_port,
   input wire logic [7:0] port_pins,
   // Register file write side
   output frs_pkg::frs_wr_t file_wr,
   // Timer zero prescaler
   input wire logic prescaler_on_timer,
   output logic prescaler_clr,
   // Core state
   output logic [7:0] acc,
   output frs_pkg::frs_flags_t flags,
   output logic idle_cycle
);

   // Pick one bit of a byte
   function automatic logic bit_of(input logic [7:0] v, input logic [2:0] sel);
      bit_of = v[sel];
   endfunction

   // Byte with one bit cleared
   function automatic logic [7:0] clear_bit(input logic [7:0] v, input logic [2:0] sel);
      logic [7:0] r;
      r = v;
      r[sel] = 1'b0;
      clear_bit = r;
   endfunction

   frs_pkg::frs_state_t state_reg, state_next;
   logic [7:0] acc_reg, acc_next;
   frs_pkg::frs_flags_t flags_reg, flags_next;
   frs_pkg::frs_wr_t wr_reg, wr_next;
   logic pclr_reg, pclr_next;

   logic take;
   logic is_add, is_and, is_bclr, is_btsz;
   logic dest;
   logic [2:0] bsel;
   logic [7:0] src;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] conj;

   // Decode; words shown during the idle cycle are never taken
   assign take = instr_valid && (state_reg == frs_pkg::FRS_RUN);
   assign is_add = take && (instr_word[13:8] == `FRS_OP_ADD);
   assign is_and = take && (instr_word[13:8] == `FRS_OP_AND);
   assign is_bclr = take && (instr_word[13:10] == `FRS_OP_BCLR);
   assign is_btsz = take && (instr_word[13:10] == `FRS_OP_BTSZ);
   assign dest = instr_word[`FRS_DEST_BIT];
   assign bsel = instr_word[`FRS_BSEL_HI:`FRS_BSEL_LO];
   assign file_raddr = instr_word[6:0];

   // Source value: pins for ports, else a bypass of the write still in flight,
   // because the register file lands our write one edge late
   always_comb begin
      if (file_is_port) begin
         src = port_pins;
      end else if (wr_reg.we && wr_reg.addr == file_raddr) begin
         src = wr_reg.data;
      end else begin
         src = file_rdata;
      end
   end

   // Arithmetic
   assign sum = {1'b0, acc_reg} + {1'b0, src};
   assign low_sum = {1'b0, acc_reg[3:0]} + {1'b0, src[3:0]};
   assign conj = acc_reg & src;

   // Next values of accumulator, flags, write port and phase
   always_comb begin
      state_next = frs_pkg::FRS_RUN;
      acc_next = acc_reg;
      flags_next = flags_reg;
      wr_next = '0;
      wr_next.addr = file_raddr;
      if (is_add) begin
         flags_next.carry = sum[8];
         flags_next.nibble_overflow_flag = low_sum[4];
         flags_next.zero = (sum[7:0] == 8'h00);
         if (dest) begin
            wr_next.we = 1'b1;
            wr_next.data = sum[7:0];
         end else begin
            acc_next = sum[7:0];
         end
      end else if (is_and) begin
         flags_next.zero = (conj == 8'h00);
         if (dest) begin
            wr_next.we = 1'b1;
            wr_next.data = conj;
         end else begin
            acc_next = conj;
         end
      end else if (is_bclr) begin
         wr_next.we = 1'b1;
         wr_next.data = clear_bit(src, bsel);
      end else if (is_btsz) begin
         if (!bit_of(src, bsel)) begin
            state_next = frs_pkg::FRS_IDLE;
         end
      end
   end

   // Prescaler clear rides with the timer write
   assign pclr_next = wr_next.we && (wr_next.addr == `FRS_TMR_ADDR)
      && prescaler_on_timer;

   // Registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= frs_pkg::FRS_RUN;
         acc_reg <= `FRS_ACC_RST;
         flags_reg <= '0;
         wr_reg <= '0;
         pclr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         wr_reg <= wr_next;
         pclr_reg <= pclr_next;
      end
   end

   assign file_wr = wr_reg;
   assign acc = acc_reg;
   assign flags = flags_reg;
   assign prescaler_clr = pclr_reg;
   assign idle_cycle = (state_reg == frs_pkg::FRS_IDLE);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Sum lands in the accumulator with its carry, file untouched
   a_add_to_acc: assert property (
      is_add && !dest |=> acc_reg == $past(sum[7:0]) && flags_reg.carry == $past(sum[8])
         && !wr_reg.we)
      else $error("add to accumulator wrong");

   // Destination zero leaves the file alone
   a_add_keep_file: assert property (
      is_add && !dest |=> !file_wr.we)
      else $error("add wrote the file");

   // Destination one writes the file and keeps the accumulator
   a_add_to_file: assert property (
      is_add && dest |=> file_wr.we && file_wr.data == $past(sum[7:0]) && $stable(acc_reg))
      else $error("add to file wrong");

   // AND touches only zero
   a_and_flags: assert property (
      is_and |=> flags_reg.zero == ($past(conj) == 8'h00)
         && flags_reg.carry == $past(flags_reg.carry)
         && flags_reg.nibble_overflow_flag == $past(flags_reg.nibble_overflow_flag))
      else $error("and flags wrong");

   // AND result routing
   a_and_route: assert property (
      is_and |=> (file_wr.we == $past(dest)) && ($past(dest) || acc_reg == $past(conj)))
      else $error("and routing wrong");

   // A clear test bit idles exactly one cycle and takes nothing then
   a_skip_idle: assert property (
      is_btsz && !bit_of(src, bsel) |=> idle_cycle && !take ##1 !idle_cycle)
      else $error("skip did not idle one cycle");

   // A set test bit does not idle and changes no flag
   a_no_skip: assert property (
      is_btsz && bit_of(src, bsel) |=> !idle_cycle && $stable(flags_reg) && !file_wr.we)
      else $error("test without skip wrong");

   // Bit clear writes one bit down and keeps flags
   a_bit_clear: assert property (
      is_bclr |=> file_wr.we && file_wr.data == clear_bit($past(src), $past(bsel))
         && $stable(flags_reg) && $stable(acc_reg))
      else $error("bit clear wrong");

   // Port source comes from the pins
   a_port_pins: assert property (
      is_bclr && file_is_port |=> file_wr.data == clear_bit($past(port_pins), $past(bsel)))
      else $error("port source not from pins");

   // Prescaler clear goes with a timer write only
   a_presc_clear: assert property (
      prescaler_clr == (file_wr.we && file_wr.addr == `FRS_TMR_ADDR && $past(prescaler_on_timer)))
      else $error("prescaler clear wrong");

   // Add derives nibble carry and zero from the operands themselves
   a_add_flags: assert property (
      is_add |=> flags_reg.nibble_overflow_flag
         == (({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(src[3:0])}) > 5'h0f)
         && flags_reg.zero == ($past(acc_reg) + $past(src) == 8'h00))
      else $error("add flags wrong");

   // AND to the file keeps the accumulator and writes the conjunction
   a_and_keep_acc: assert property (
      is_and && dest |=> $stable(acc_reg) && file_wr.data == $past(acc_reg & src))
      else $error("and to file wrong");

   // The word shown in the idle slot changes nothing
   a_idle_ignores: assert property (
      idle_cycle |=> $stable(acc_reg) && $stable(flags_reg) && !file_wr.we && !prescaler_clr)
      else $error("word taken in idle slot");

   // A test leaves accumulator and file alone
   a_test_no_write: assert property (
      is_btsz |=> $stable(acc_reg) && !file_wr.we)
      else $error("test wrote a result");

   // Bit clear writes back to the address it read
   a_bclr_addr: assert property (
      is_bclr |=> file_wr.addr == $past(instr_word[6:0]))
      else $error("bit clear address wrong");

endmodule
`default_nettype wire

// ==== testbench/frs_exec_test.sv ====
/*
 Self-checking bench for frs_exec: random add, AND, bit clear, test-skip and
 undecoded words, with a reference model in the bench's own stimulus loop.
 Assumes the one-cycle answer, the write bypass and the reset of the notes.
*/
`timescale 1ns/1ns
`default_nettype none
module frs_exec_test;
   logic clk, rst_n, instr_valid, file_is_port, prescaler_on_timer, prescaler_clr, idle_cycle;
   logic [13:0] instr_word;
   logic [7:0] file_rdata, port_pins, acc, src, res, e_acc;
   logic [6:0] file_raddr, a;
   logic [8:0] s9;
   logic [2:0] e_flg, b;
   logic [15:0] e_wr;
   logic [31:0] lfsr, r;
   logic e_clr, e_idle, d;
   frs_pkg::frs_wr_t file_wr;
   frs_pkg::frs_flags_t flags;
   int errors, n_checks;

   frs_exec i_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr_word(instr_word), .file_raddr(file_raddr), .file_rdata(file_rdata),
      .file_is_port(file_is_port), .port_pins(port_pins), .file_wr(file_wr),
      .prescaler_on_timer(prescaler_on_timer), .prescaler_clr(prescaler_clr),
      .acc(acc), .flags(flags), .idle_cycle(idle_cycle));

   // Free-running clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Galois shift register, fixed seed keeps runs repeatable
   function automatic logic [31:0] next_rnd(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction

   // Carry, nibble carry and zero of an add, worked out from the operands
   function automatic logic [2:0] add_flags(input logic [7:0] x, input logic [7:0] y);
      logic [8:0] t;
      logic [4:0] n;
      t = {1'b0, x} + {1'b0, y};
      n = {1'b0, x[3:0]} + {1'b0, y[3:0]};
      return {t[8], n[4], t[7:0] == 8'h00};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Compare what the last edge produced, then drive and predict the next
   initial begin
      errors = 0;
      n_checks = 0;
      lfsr = 32'he9271e50;
      {rst_n, instr_valid, file_is_port, prescaler_on_timer} = 4'h0;
      instr_word = 14'h0000;
      {file_rdata, port_pins} = 16'h0000;
      {e_acc, e_flg, e_wr, e_clr, e_idle} = 29'h0;
      for (int i = 0; i < 3000; i++) begin
         @(negedge clk);
         check({8'h00, acc}, {8'h00, e_acc});
         check({13'h0000, flags}, {13'h0000, e_flg});
         check(file_wr, e_wr);
         check({15'h0000, prescaler_clr}, {15'h0000, e_clr});
         check({15'h0000, idle_cycle}, {15'h0000, e_idle});
         lfsr = next_rnd(lfsr);
         r = lfsr;
         rst_n = !(i < 2 || i == 1500);
         instr_valid = r[31:29] != 3'h0;
         d = r[7];
         b = r[10:8];
         a = r[28] ? 7'h01 : (r[27] ? e_wr[14:8] : r[6:0]);
         case (r[13:11] % 5)
            0: instr_word = {6'h07, d, a};
            1: instr_word = {6'h05, d, a};
            2: instr_word = {4'h4, b, a};
            3: instr_word = {4'h6, b, a};
            default: instr_word = {6'h00, d, a};
         endcase
         file_is_port = r[26:24] == 3'h0;
         prescaler_on_timer = r[23];
         port_pins = r[22:15];
         file_rdata = (r[3:0] == 4'h0) ? 8'h00 - e_acc : r[21:14] ^ 8'h5a;
         #1;
         check({9'h000, file_raddr}, {9'h000, instr_word[6:0]});
         // Pins win on ports; otherwise the write still in flight is bypassed
         if (file_is_port) begin
            src = port_pins;
         end else if (e_wr[15] && e_wr[14:8] == a) begin
            src = e_wr[7:0];
         end else begin
            src = file_rdata;
         end
         s9 = {1'b0, e_acc} + {1'b0, src};
         // Out of reset, the write port keeps showing the decoded address when nothing is written
         e_wr = {1'b0, (rst_n ? a : 7'h00), 8'h00};
         res = 8'h00;
         if (!rst_n) begin
            {e_acc, e_flg, e_idle} = 12'h000;
         end else if (!instr_valid || e_idle) begin
            e_idle = 1'b0; // Word ignored during the idle slot
         end else begin
            e_idle = 1'b0;
            case (instr_word[13:8])
               6'h07: begin
                  res = s9[7:0];
                  e_flg = add_flags(e_acc, src);
               end
               6'h05: begin
                  res = e_acc & src;
                  e_flg[0] = res == 8'h00;
               end
               default: ;
            endcase
            if (instr_word[13:10] == 4'h6) begin
               e_idle = ~src[b];
            end else if (instr_word[13:10] == 4'h4) begin
               e_wr = {1'b1, a, src & ~(8'h01 << b)};
            end else if (instr_word[13:8] == 6'h07 || instr_word[13:8] == 6'h05) begin
               if (d) begin
                  e_wr = {1'b1, a, res};
               end else begin
                  e_acc = res;
               end
            end
         end
         e_clr = e_wr[15] && e_wr[14:8] == 7'h01 && prescaler_on_timer;
      end
      end_of_test();
   end
endmodule
`default_nettype wire
